// [design/ddc_decim_nco_top.sv]
// control top: registers, decimation chain select, input routing, oscillator channel select
`timescale 1ns/10ps
// Contract
// R1: primary code 101 chains half-band 1, 2, third-band; factor 6 or 12.
// R2: primary code 110 chains half-band 1, 2, 3, third-band; factor 12 or 24.
// R3: primary code 111 takes chain and factor from input-select upper nibble.
// R4: extended field has effect only while primary code is all ones.
// R5: extended 0 chains third-band, half-band 4..1; factor 48, or 24 real.
// R6: extended 2 chains fifth-band, half-band 1; factor 10, or 5 real.
// R7: extended 3 chains fifth-band, half-band 2, 1; factor 20, or 10 real.
// R8: extended 4 chains fifth-band, half-band 3..1; factor 40, or 20 real.
// R9: input-select bit 2 routes A or B to Q path; B after reset.
// R10: input-select bit 0 routes A or B to I path; B after reset.
// R11: mode zero takes oscillator channel from register channel field.
// R12: pin mode forms channel as zeros, pin B level, pin A level.
// R13: edge mode A advances channel counter on each pin A rising edge.
// R14: edge mode B advances channel counter on each pin B rising edge.
// R15: edge counter wraps to zero after reaching register channel field.
// R16: channel field value n selects oscillator channel n.
// R17: complex-to-real bit gives real I output only via quarter-rate mix.
// R18: channel encoding spans full four bits, up to channel 15.
// R19: edge counter clears on reset and on any select mode change.
module ddc_decim_nco_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic select_pin_a,
   input wire logic select_pin_b,
   output logic [7:0] reg_rdata_ff,
   output logic reg_rvalid_ff,
   output logic [5:0] stage_en_ff,
   output logic [5:0] decim_factor_ff,
   output logic decim_invalid_ff,
   output logic real_only_ff,
   output logic i_src_b_ff,
   output logic q_src_b_ff,
   output logic [3:0] osc_channel_ff
);
   logic [7:0] ctrl_ff;
   logic [7:0] insel_ff;
   logic [7:0] osc_ff;
   logic [3:0] edge_cnt_ff;
   logic pin_a_prev_ff;
   logic pin_b_prev_ff;
   logic wr_ctrl;
   logic wr_insel;
   logic wr_osc;
   logic mode_change;
   logic rise_a;
   logic rise_b;
   logic edge_evt;
   logic [3:0] mode;
   logic [3:0] chan_field;
   logic [3:0] nxt_channel;
   logic [3:0] nxt_cnt;

   ddc_decim_if dif ();

   assign wr_ctrl = reg_wr && (reg_addr == ddc_pkg::DDC_ADDR_CTRL);
   assign wr_insel = reg_wr && (reg_addr == ddc_pkg::DDC_ADDR_INSEL);
   assign wr_osc = reg_wr && (reg_addr == ddc_pkg::DDC_ADDR_OSC);
   assign mode = osc_ff[7:ddc_pkg::DDC_POS_HI];
   assign chan_field = osc_ff[3:0];

   // register file
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= ddc_pkg::DDC_RST_CTRL;
      end else if (wr_ctrl) begin
         ctrl_ff <= reg_wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         insel_ff <= ddc_pkg::DDC_RST_INSEL; // R9 R10
      end else if (wr_insel) begin
         insel_ff <= reg_wdata & ddc_pkg::DDC_INSEL_MASK;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         osc_ff <= ddc_pkg::DDC_RST_OSC;
      end else if (wr_osc) begin
         osc_ff <= reg_wdata;
      end
   end

   // reads answer one cycle later; unmapped addresses read zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_ff <= 8'h00;
         reg_rvalid_ff <= 1'b0;
      end else begin
         reg_rvalid_ff <= reg_rd;
         if (!reg_rd) begin
            reg_rdata_ff <= 8'h00;
         end else begin
            case (reg_addr)
               ddc_pkg::DDC_ADDR_CTRL: reg_rdata_ff <= ctrl_ff;
               ddc_pkg::DDC_ADDR_INSEL: reg_rdata_ff <= insel_ff;
               ddc_pkg::DDC_ADDR_OSC: reg_rdata_ff <= osc_ff;
               default: reg_rdata_ff <= 8'h00;
            endcase
         end
      end
   end

   // decimation chain
   assign dif.dec_code = ctrl_ff[2:0];
   assign dif.ext_code = insel_ff[7:ddc_pkg::DDC_POS_HI]; // R3
   assign dif.c2r = ctrl_ff[ddc_pkg::DDC_POS_C2R];

   ddc_decim_decode u_decode (
      .d(dif.dec)
   );

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stage_en_ff <= ddc_pkg::DDC_STG_HB1 | ddc_pkg::DDC_STG_HB2;
         decim_factor_ff <= ddc_pkg::DDC_RST_FACTOR;
         decim_invalid_ff <= 1'b0;
         real_only_ff <= 1'b0;
      end else begin
         stage_en_ff <= dif.stages; // R1 R2 R5 R6 R7 R8
         decim_factor_ff <= dif.factor;
         decim_invalid_ff <= dif.invalid;
         real_only_ff <= dif.c2r; // R17
      end
   end

   // input routing
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         i_src_b_ff <= 1'b1;
         q_src_b_ff <= 1'b1;
      end else begin
         i_src_b_ff <= insel_ff[ddc_pkg::DDC_POS_I_SEL]; // R10
         q_src_b_ff <= insel_ff[ddc_pkg::DDC_POS_Q_SEL]; // R9
      end
   end

   // pin edge detect; pins are synchronous to mclk by contract
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_a_prev_ff <= 1'b0;
         pin_b_prev_ff <= 1'b0;
      end else begin
         pin_a_prev_ff <= select_pin_a;
         pin_b_prev_ff <= select_pin_b;
      end
   end

   assign rise_a = select_pin_a && !pin_a_prev_ff;
   assign rise_b = select_pin_b && !pin_b_prev_ff;
   assign edge_evt = ((mode == ddc_pkg::DDC_MODE_EDGE_A) && rise_a) // R13
                     || ((mode == ddc_pkg::DDC_MODE_EDGE_B) && rise_b); // R14
   assign mode_change = wr_osc && (reg_wdata[7:ddc_pkg::DDC_POS_HI] != mode);

   always_comb begin
      if (edge_cnt_ff >= chan_field) begin
         nxt_cnt = 4'h0; // R15
      end else begin
         nxt_cnt = edge_cnt_ff + 4'h1;
      end
   end

   // a mode change in the same cycle as an edge restarts the count
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         edge_cnt_ff <= 4'h0; // R19
      end else if (mode_change) begin
         edge_cnt_ff <= 4'h0; // R19
      end else if (edge_evt) begin
         edge_cnt_ff <= nxt_cnt; // R13 R14 R15
      end
   end

   // undefined modes fall back to the register field
   always_comb begin
      case (mode)
         ddc_pkg::DDC_MODE_PINS: nxt_channel = {2'h0, select_pin_b, select_pin_a}; // R12
         ddc_pkg::DDC_MODE_EDGE_A: nxt_channel = edge_cnt_ff;
         ddc_pkg::DDC_MODE_EDGE_B: nxt_channel = edge_cnt_ff;
         default: nxt_channel = chan_field; // R11 R16 R18
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         osc_channel_ff <= 4'h0;
      end else begin
         osc_channel_ff <= nxt_channel;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence ctrl_written_s(logic [2:0] code, logic c2r);
      wr_ctrl && reg_wdata[2:0] == code && reg_wdata[ddc_pkg::DDC_POS_C2R] == c2r;
   endsequence

   sequence quiet_s;
      !reg_wr [*2];
   endsequence

   chain_101_a: assert property ( // R1
      (ctrl_written_s(3'h5, 1'b0) ##1 quiet_s) |-> ##0 stage_en_ff == 6'h13
      && decim_factor_ff == 6'h0c)
      else $error("code 101 chain or factor wrong");

   chain_110_real_a: assert property ( // R2
      (ctrl_written_s(3'h6, 1'b1) ##1 quiet_s) |-> ##0 stage_en_ff == 6'h17
      && decim_factor_ff == 6'h0c && real_only_ff)
      else $error("code 110 real chain or factor wrong");

   ext_ignored_a: assert property ( // R4
      (ctrl_ff[2:0] != 3'h7 && $stable(ctrl_ff) && $changed(insel_ff[7:4]))
      |=> $stable(stage_en_ff) && $stable(decim_factor_ff))
      else $error("extended field acted outside code 111");

   ext_zero_a: assert property ( // R3 R5
      (ctrl_ff == 8'h07 && insel_ff[7:4] == 4'h0) |=> stage_en_ff == 6'h1f
      && decim_factor_ff == 6'h30)
      else $error("extended 0 chain or factor wrong");

   ext_fifth_a: assert property ( // R6 real case
      (ctrl_ff == 8'h0f && insel_ff[7:4] == 4'h2) |=> stage_en_ff == 6'h21
      && decim_factor_ff == 6'h05)
      else $error("extended 2 real chain or factor wrong");

   ext_forty_a: assert property ( // R8
      (ctrl_ff == 8'h07 && insel_ff[7:4] == 4'h4) |=> stage_en_ff == 6'h27
      && decim_factor_ff == 6'h28)
      else $error("extended 4 chain or factor wrong");

   route_q_i_a: assert property ( // R9 R10
      (wr_insel ##1 !wr_insel) |=> q_src_b_ff == $past(reg_wdata[2], 2)
      && i_src_b_ff == $past(reg_wdata[0], 2))
      else $error("input routing does not follow register");

   mode_reg_a: assert property ( // R11 R16 R18
      mode == ddc_pkg::DDC_MODE_REG |=> osc_channel_ff == $past(chan_field))
      else $error("register channel select not followed");

   mode_pins_a: assert property ( // R12
      mode == ddc_pkg::DDC_MODE_PINS
      |=> osc_channel_ff == {2'h0, $past(select_pin_b), $past(select_pin_a)})
      else $error("pin channel select wrong");

   edge_step_a: assert property ( // R13 R14
      (edge_evt && !mode_change && edge_cnt_ff < chan_field)
      |=> edge_cnt_ff == $past(edge_cnt_ff) + 4'h1)
      else $error("edge counter did not advance");

   edge_wrap_a: assert property ( // R15
      (edge_evt && !mode_change && edge_cnt_ff == chan_field) |=> edge_cnt_ff == 4'h0)
      else $error("edge counter did not wrap");

   mode_clear_a: assert property ( // R19
      mode_change |=> edge_cnt_ff == 4'h0 ##1 (osc_channel_ff == 4'h0
      || !($past(mode) == ddc_pkg::DDC_MODE_EDGE_A || $past(mode) == ddc_pkg::DDC_MODE_EDGE_B)))
      else $error("edge counter not cleared on mode change");
endmodule : ddc_decim_nco_top

// [design/ddc_pkg.sv]
// shared constants for the third downconverter decimation and oscillator select block
package ddc_pkg;
   // register addresses
   localparam logic [15:0] DDC_ADDR_CTRL = 16'h0370;
   localparam logic [15:0] DDC_ADDR_INSEL = 16'h0371;
   localparam logic [15:0] DDC_ADDR_OSC = 16'h0374;
   // values after reset
   localparam logic [7:0] DDC_RST_CTRL = 8'h00;
   localparam logic [7:0] DDC_RST_INSEL = 8'h05;
   localparam logic [7:0] DDC_RST_OSC = 8'h00;
   localparam logic [5:0] DDC_RST_FACTOR = 6'h04;
   // field positions
   localparam int DDC_POS_C2R = 3;
   localparam int DDC_POS_Q_SEL = 2;
   localparam int DDC_POS_I_SEL = 0;
   localparam int DDC_POS_HI = 4;
   // writable bits of the input-select register, reserved bits read zero
   localparam logic [7:0] DDC_INSEL_MASK = 8'hf5;
   // primary decimation codes
   localparam logic [2:0] DDC_DEC_HB12 = 3'h0;
   localparam logic [2:0] DDC_DEC_HB123 = 3'h1;
   localparam logic [2:0] DDC_DEC_HB1234 = 3'h2;
   localparam logic [2:0] DDC_DEC_HB1 = 3'h3;
   localparam logic [2:0] DDC_DEC_HB1_TB = 3'h4;
   localparam logic [2:0] DDC_DEC_HB12_TB = 3'h5;
   localparam logic [2:0] DDC_DEC_HB123_TB = 3'h6;
   localparam logic [2:0] DDC_DEC_EXT = 3'h7;
   // extended decimation codes
   localparam logic [3:0] DDC_EXT_TB_HB4321 = 4'h0;
   localparam logic [3:0] DDC_EXT_FB_HB1 = 4'h2;
   localparam logic [3:0] DDC_EXT_FB_HB21 = 4'h3;
   localparam logic [3:0] DDC_EXT_FB_HB321 = 4'h4;
   // stage enable bits: [0..3] half-band 1..4, [4] third-band, [5] fifth-band
   localparam logic [5:0] DDC_STG_HB1 = 6'h01;
   localparam logic [5:0] DDC_STG_HB2 = 6'h02;
   localparam logic [5:0] DDC_STG_HB3 = 6'h04;
   localparam logic [5:0] DDC_STG_HB4 = 6'h08;
   localparam logic [5:0] DDC_STG_TB = 6'h10;
   localparam logic [5:0] DDC_STG_FB = 6'h20;
   // oscillator channel select modes
   localparam logic [3:0] DDC_MODE_REG = 4'h0;
   localparam logic [3:0] DDC_MODE_PINS = 4'h8;
   localparam logic [3:0] DDC_MODE_EDGE_A = 4'h9;
   localparam logic [3:0] DDC_MODE_EDGE_B = 4'ha;
endpackage : ddc_pkg

// [design/ddc_decim_if.sv]
// carrier between the register side and the decimation decoder
`timescale 1ns/10ps
interface ddc_decim_if;
   logic [2:0] dec_code;
   logic [3:0] ext_code;
   logic c2r;
   logic [5:0] stages;
   logic [5:0] factor;
   logic invalid;
   modport ctl (output dec_code, output ext_code, output c2r,
                input stages, input factor, input invalid);
   modport dec (input dec_code, input ext_code, input c2r,
                output stages, output factor, output invalid);
endinterface : ddc_decim_if

// [design/ddc_decim_decode.sv]
// decoder from decimation codes to filter stage chain and overall factor
`timescale 1ns/10ps
module ddc_decim_decode (
   ddc_decim_if.dec d
);
   logic [5:0] cplx_factor;

   always_comb begin
      d.stages = ddc_pkg::DDC_STG_HB1;
      cplx_factor = 6'h02;
      d.invalid = 1'b0;
      case (d.dec_code)
         ddc_pkg::DDC_DEC_HB12: begin
            d.stages = ddc_pkg::DDC_STG_HB1 | ddc_pkg::DDC_STG_HB2;
            cplx_factor = 6'h04;
         end
         ddc_pkg::DDC_DEC_HB123: begin
            d.stages = ddc_pkg::DDC_STG_HB1 | ddc_pkg::DDC_STG_HB2 | ddc_pkg::DDC_STG_HB3;
            cplx_factor = 6'h08;
         end
         ddc_pkg::DDC_DEC_HB1234: begin
            d.stages = ddc_pkg::DDC_STG_HB1 | ddc_pkg::DDC_STG_HB2 | ddc_pkg::DDC_STG_HB3
                       | ddc_pkg::DDC_STG_HB4;
            cplx_factor = 6'h10;
         end
         ddc_pkg::DDC_DEC_HB1: begin
            d.stages = ddc_pkg::DDC_STG_HB1;
            cplx_factor = 6'h02;
         end
         ddc_pkg::DDC_DEC_HB1_TB: begin
            d.stages = ddc_pkg::DDC_STG_HB1 | ddc_pkg::DDC_STG_TB;
            cplx_factor = 6'h06;
         end
         ddc_pkg::DDC_DEC_HB12_TB: begin // R1
            d.stages = ddc_pkg::DDC_STG_HB1 | ddc_pkg::DDC_STG_HB2 | ddc_pkg::DDC_STG_TB;
            cplx_factor = 6'h0c;
         end
         ddc_pkg::DDC_DEC_HB123_TB: begin // R2
            d.stages = ddc_pkg::DDC_STG_HB1 | ddc_pkg::DDC_STG_HB2 | ddc_pkg::DDC_STG_HB3
                       | ddc_pkg::DDC_STG_TB;
            cplx_factor = 6'h18;
         end
         default: begin // R3 R4
            case (d.ext_code)
               ddc_pkg::DDC_EXT_TB_HB4321: begin // R5
                  d.stages = ddc_pkg::DDC_STG_TB | ddc_pkg::DDC_STG_HB4 | ddc_pkg::DDC_STG_HB3
                             | ddc_pkg::DDC_STG_HB2 | ddc_pkg::DDC_STG_HB1;
                  cplx_factor = 6'h30;
               end
               ddc_pkg::DDC_EXT_FB_HB1: begin // R6
                  d.stages = ddc_pkg::DDC_STG_FB | ddc_pkg::DDC_STG_HB1;
                  cplx_factor = 6'h0a;
               end
               ddc_pkg::DDC_EXT_FB_HB21: begin // R7
                  d.stages = ddc_pkg::DDC_STG_FB | ddc_pkg::DDC_STG_HB2 | ddc_pkg::DDC_STG_HB1;
                  cplx_factor = 6'h14;
               end
               ddc_pkg::DDC_EXT_FB_HB321: begin // R8
                  d.stages = ddc_pkg::DDC_STG_FB | ddc_pkg::DDC_STG_HB3 | ddc_pkg::DDC_STG_HB2
                             | ddc_pkg::DDC_STG_HB1;
                  cplx_factor = 6'h28;
               end
               default: begin
                  // undefined extended code: flag it, fall back to half-band 1
                  d.invalid = 1'b1;
               end
            endcase
         end
      endcase
      // real output halves the decimation factor because the extra quarter-rate mix keeps only I
      d.factor = d.c2r ? {1'b0, cplx_factor[5:1]} : cplx_factor;
   end
endmodule : ddc_decim_decode

// [verification/ddc_pin_ctl.sv]
// external controller model driving the two oscillator select pins
`timescale 1ns/10ps
module ddc_pin_ctl (
   input wire logic mclk,
   output logic select_pin_a,
   output logic select_pin_b
);
   initial begin
      select_pin_a = 1'b0;
      select_pin_b = 1'b0;
   end
   task automatic set_levels(input logic a, input logic b);
      @(posedge mclk);
      select_pin_a <= a;
      select_pin_b <= b;
      repeat (3) @(posedge mclk);
   endtask : set_levels
   // each level held two cycles or more, so every rise is seen once
   task automatic rise(input logic on_b);
      @(posedge mclk);
      if (on_b) select_pin_b <= 1'b0;
      else select_pin_a <= 1'b0;
      repeat (2) @(posedge mclk);
      if (on_b) select_pin_b <= 1'b1;
      else select_pin_a <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask : rise
endmodule : ddc_pin_ctl

// [verification/tb.sv]
// self-checking bench for the decimation and oscillator select block
`timescale 1ns/10ps
module tb;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] insel;
      logic [5:0] stg;
      logic [5:0] fac;
      logic c2r;
      logic isb;
      logic qsb;
   } ddc_row_t;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic select_pin_a;
   logic select_pin_b;
   logic [7:0] reg_rdata_ff;
   logic reg_rvalid_ff;
   logic [5:0] stage_en_ff;
   logic [5:0] decim_factor_ff;
   logic decim_invalid_ff;
   logic real_only_ff;
   logic i_src_b_ff;
   logic q_src_b_ff;
   logic [3:0] osc_channel_ff;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   ddc_row_t rows [0:17] = '{
      '{8'h05, 8'h00, 6'h13, 6'h0c, 1'h0, 1'h0, 1'h0},
      '{8'h0d, 8'h01, 6'h13, 6'h06, 1'h1, 1'h1, 1'h0},
      '{8'h06, 8'h04, 6'h17, 6'h18, 1'h0, 1'h0, 1'h1},
      '{8'h0e, 8'h05, 6'h17, 6'h0c, 1'h1, 1'h1, 1'h1},
      '{8'h07, 8'h05, 6'h1f, 6'h30, 1'h0, 1'h1, 1'h1},
      '{8'h0f, 8'h05, 6'h1f, 6'h18, 1'h1, 1'h1, 1'h1},
      '{8'h07, 8'h25, 6'h21, 6'h0a, 1'h0, 1'h1, 1'h1},
      '{8'h0f, 8'h25, 6'h21, 6'h05, 1'h1, 1'h1, 1'h1},
      '{8'h07, 8'h35, 6'h23, 6'h14, 1'h0, 1'h1, 1'h1},
      '{8'h0f, 8'h35, 6'h23, 6'h0a, 1'h1, 1'h1, 1'h1},
      '{8'h07, 8'h45, 6'h27, 6'h28, 1'h0, 1'h1, 1'h1},
      '{8'h0f, 8'h45, 6'h27, 6'h14, 1'h1, 1'h1, 1'h1},
      '{8'h05, 8'h45, 6'h13, 6'h0c, 1'h0, 1'h1, 1'h1},
      '{8'h00, 8'h45, 6'h03, 6'h04, 1'h0, 1'h1, 1'h1},
      '{8'h09, 8'h45, 6'h07, 6'h04, 1'h1, 1'h1, 1'h1},
      '{8'h02, 8'h45, 6'h0f, 6'h10, 1'h0, 1'h1, 1'h1},
      '{8'h0b, 8'h45, 6'h01, 6'h01, 1'h1, 1'h1, 1'h1},
      '{8'h04, 8'h45, 6'h11, 6'h06, 1'h0, 1'h1, 1'h1}};
   always #5 mclk = ~mclk;
   ddc_decim_nco_top dut (
      .mclk(mclk),
      .rst_n(rst_n),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .select_pin_a(select_pin_a),
      .select_pin_b(select_pin_b),
      .reg_rdata_ff(reg_rdata_ff),
      .reg_rvalid_ff(reg_rvalid_ff),
      .stage_en_ff(stage_en_ff),
      .decim_factor_ff(decim_factor_ff),
      .decim_invalid_ff(decim_invalid_ff),
      .real_only_ff(real_only_ff),
      .i_src_b_ff(i_src_b_ff),
      .q_src_b_ff(q_src_b_ff),
      .osc_channel_ff(osc_channel_ff)
   );
   ddc_pin_ctl pins (
      .mclk(mclk),
      .select_pin_a(select_pin_a),
      .select_pin_b(select_pin_b)
   );
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk("rvalid", 8'h01, {7'h00, reg_rvalid_ff});
      chk("rdata", exp, reg_rdata_ff);
   endtask : rd
   // settle time for derived outputs after a write
   task automatic osc(input logic [7:0] d, input logic [3:0] exp);
      wr(ddc_pkg::DDC_ADDR_OSC, d);
      repeat (2) @(posedge mclk);
      #1;
      chk("channel", {4'h0, exp}, {4'h0, osc_channel_ff});
   endtask : osc
   task automatic rise_chk(input logic on_b, input logic [3:0] exp);
      pins.rise(on_b);
      #1;
      chk("edge channel", {4'h0, exp}, {4'h0, osc_channel_ff});
   endtask : rise_chk
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         $display("[ERR] timeout expected done seen hang");
         summarize();
      end
   end
   initial begin
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      chk("rst stages", 8'h03, {2'h0, stage_en_ff});
      chk("rst factor", 8'h04, {2'h0, decim_factor_ff});
      chk("rst src", 8'h03, {6'h00, i_src_b_ff, q_src_b_ff});
      chk("rst chan", 8'h00, {4'h0, osc_channel_ff});
      chk("rst misc", 8'h00, {5'h00, reg_rvalid_ff, real_only_ff, decim_invalid_ff});
      chk("rst rdata", 8'h00, reg_rdata_ff);
      rd(ddc_pkg::DDC_ADDR_CTRL, ddc_pkg::DDC_RST_CTRL);
      rd(ddc_pkg::DDC_ADDR_INSEL, 8'h05);
      rd(ddc_pkg::DDC_ADDR_OSC, 8'h00);
      rd(16'h0372, 8'h00);
      wr(ddc_pkg::DDC_ADDR_INSEL, 8'hff);
      rd(ddc_pkg::DDC_ADDR_INSEL, 8'hf5);
      foreach (rows[k]) begin
         wr(ddc_pkg::DDC_ADDR_INSEL, rows[k].insel);
         wr(ddc_pkg::DDC_ADDR_CTRL, rows[k].ctrl);
         @(posedge mclk);
         #1;
         chk("stages", {2'h0, rows[k].stg}, {2'h0, stage_en_ff});
         chk("factor", {2'h0, rows[k].fac}, {2'h0, decim_factor_ff});
         chk("invalid", 8'h00, {7'h00, decim_invalid_ff});
         chk("real", {7'h00, rows[k].c2r}, {7'h00, real_only_ff});
         chk("i src", {7'h00, rows[k].isb}, {7'h00, i_src_b_ff});
         chk("q src", {7'h00, rows[k].qsb}, {7'h00, q_src_b_ff});
      end
      // undefined extended code: half-band 1 only, flagged
      wr(ddc_pkg::DDC_ADDR_INSEL, 8'h15);
      wr(ddc_pkg::DDC_ADDR_CTRL, 8'h07);
      @(posedge mclk);
      #1;
      chk("bad ext stages", 8'h01, {2'h0, stage_en_ff});
      chk("bad ext factor", 8'h02, {2'h0, decim_factor_ff});
      chk("bad ext invalid", 8'h01, {7'h00, decim_invalid_ff});
      rd(ddc_pkg::DDC_ADDR_CTRL, 8'h07);
      osc(8'h0b, 4'hb);
      osc(8'h0f, 4'hf);
      osc(8'h80, 4'h0);
      pins.set_levels(1'b1, 1'b0);
      #1;
      chk("pin channel", 8'h01, {4'h0, osc_channel_ff});
      pins.set_levels(1'b0, 1'b1);
      #1;
      chk("pin channel", 8'h02, {4'h0, osc_channel_ff});
      pins.set_levels(1'b0, 1'b0);
      osc(8'h92, 4'h0);
      rise_chk(1'b0, 4'h1);
      rise_chk(1'b0, 4'h2);
      rise_chk(1'b0, 4'h0);
      osc(8'ha3, 4'h0);
      rise_chk(1'b1, 4'h1);
      rise_chk(1'b0, 4'h1);
      rise_chk(1'b1, 4'h2);
      osc(8'h93, 4'h0);
      summarize();
   end
endmodule : tb
